//--- rtl/iafms_pkg.sv
// Package for the in-application flash mailbox sequencer.
// Holds SFR offsets, command codes, field positions, reset values and timing constants.
package iafms_pkg;

    // Mailbox register offsets on the special function register bus.
    localparam logic [7:0] IAFMS_OFS_CFG = 8'hF7;
    localparam logic [7:0] IAFMS_OFS_DATA = 8'hF8;
    localparam logic [7:0] IAFMS_OFS_ADDR_LO = 8'hF9;
    localparam logic [7:0] IAFMS_OFS_ADDR_HI = 8'hFA;
    localparam logic [7:0] IAFMS_OFS_CMD = 8'hFB;

    // Command codes in the low seven bits; bit 7 asks for an interrupt.
    localparam logic [6:0] IAFMS_CMD_CHIP_ERASE = 7'h07;
    localparam logic [6:0] IAFMS_CMD_BLOCK_ERASE = 7'h0F;
    localparam logic [6:0] IAFMS_CMD_SECTOR_ERASE = 7'h0B;
    localparam logic [6:0] IAFMS_CMD_BYTE_PROG = 7'h0E;
    localparam logic [6:0] IAFMS_CMD_BURST_PROG = 7'h0A;
    localparam logic [6:0] IAFMS_CMD_BYTE_VERIFY = 7'h0C;
    localparam int IAFMS_CMD_IRQ_BIT = 7;

    // Erase safeguard key, erased value and block-select nibble values.
    localparam logic [7:0] IAFMS_ERASE_KEY = 8'h55;
    localparam logic [7:0] IAFMS_ERASED = 8'hFF;
    localparam logic [3:0] IAFMS_SEL_PRIMARY = 4'h0;
    localparam logic [3:0] IAFMS_SEL_SECONDARY = 4'hF;

    // Configuration/status field positions.
    localparam int IAFMS_CFG_BUSY_BIT = 3;
    localparam int IAFMS_CFG_LOCK_PRI_BIT = 4;
    localparam int IAFMS_CFG_LOCK_SEC_BIT = 5;
    localparam int IAFMS_CFG_PC_SEC_BIT = 6;
    localparam logic [2:0] IAFMS_PRESCALE_RESET = 3'h0;

    // Sector sizes as address mask widths: 128 bytes and 64 bytes.
    localparam int IAFMS_PRI_SECTOR_BITS = 7;
    localparam int IAFMS_SEC_SECTOR_BITS = 6;

    // Base times per prescale step; cycles derived at 250 MHz, rounded up.
    localparam int IAFMS_CLK_MHZ = 250;
    localparam int IAFMS_PROG_TIME_NS = 40;
    localparam int IAFMS_ERASE_TIME_NS = 400;
    localparam int IAFMS_PROG_CYCLES = (IAFMS_PROG_TIME_NS * IAFMS_CLK_MHZ + 999) / 1000;
    localparam int IAFMS_ERASE_CYCLES = (IAFMS_ERASE_TIME_NS * IAFMS_CLK_MHZ + 999) / 1000;
    localparam int IAFMS_TIMER_W = 16;

endpackage : iafms_pkg

//--- rtl/iafms_timer.sv
// Operation timer for the flash sequencer: counts a base length scaled by the prescale factor.
// Assumes a start pulse only while idle; done is a one-cycle pulse at the end of the count.
`timescale 1ns/10ps
module iafms_timer
    import iafms_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire logic erase_i,
    input wire logic [2:0] clock_prescale_factor_i,
    output logic done_o
);

    typedef struct packed {
        logic [IAFMS_TIMER_W-1:0] cnt;
        logic run;
        logic done;
    } iafms_tmr_t;

    iafms_tmr_t s_q, s_d;

    // Length grows with the prescale factor so a faster clock still meets flash timing.
    function automatic logic [IAFMS_TIMER_W-1:0] iafms_len(input logic er, input logic [2:0] f);
        logic [IAFMS_TIMER_W-1:0] base;
        base = er ? IAFMS_TIMER_W'(IAFMS_ERASE_CYCLES) : IAFMS_TIMER_W'(IAFMS_PROG_CYCLES);
        return IAFMS_TIMER_W'(base * ({13'h0000, f} + 16'h0001));
    endfunction

    // Count down from the scaled length and pulse done when it reaches zero.
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start_i) begin
            s_d.run = 1'b1;
            s_d.cnt = iafms_len(erase_i, clock_prescale_factor_i) - 16'h0001;
        end else if (s_q.run) begin
            if (s_q.cnt == '0) begin
                s_d.run = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - 16'h0001;
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done_o = s_q.done;

endmodule // iafms_timer

//--- rtl/iafms_array.sv
// Flash storage model for the sequencer: primary 32K and secondary 4K blocks as register arrays.
// Assumes one operation at a time from the sequencer; reads are registered one cycle.
`timescale 1ns/10ps
module iafms_array
    import iafms_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic prog_i,
    input wire logic erase_chip_i,
    input wire logic erase_block_i,
    input wire logic erase_sector_i,
    output logic [7:0] rdata_o
);

    logic [7:0] pri_mem [0:32767];
    logic [7:0] sec_mem [0:4095];
    logic [7:0] rdata_q;

    // Secondary block lives at F000h-FFFFh, everything else maps to the primary block.
    function automatic logic is_sec(input logic [15:0] a);
        return a[15:12] == IAFMS_SEL_SECONDARY;
    endfunction

    // Erase sets bytes to the erased value; program can only clear bits, as real flash does.
    always_ff @(posedge sys_clk_i) begin
        if (erase_chip_i || erase_block_i || erase_sector_i) begin // Sweep the arrays only on an erase.
            for (int i = 0; i < 32768; i++) begin
                if (erase_chip_i || (erase_block_i && !is_sec(addr_i)) || (erase_sector_i && !is_sec(addr_i)
                        && (i[14:IAFMS_PRI_SECTOR_BITS] == addr_i[14:IAFMS_PRI_SECTOR_BITS]))) begin
                    pri_mem[i] <= IAFMS_ERASED;
                end
            end
            for (int j = 0; j < 4096; j++) begin
                if (erase_chip_i || (erase_block_i && is_sec(addr_i)) || (erase_sector_i && is_sec(addr_i)
                        && (j[11:IAFMS_SEC_SECTOR_BITS] == addr_i[11:IAFMS_SEC_SECTOR_BITS]))) begin
                    sec_mem[j] <= IAFMS_ERASED;
                end
            end
        end
        if (prog_i && is_sec(addr_i)) begin
            sec_mem[addr_i[11:0]] <= sec_mem[addr_i[11:0]] & wdata_i;
        end else if (prog_i) begin
            pri_mem[addr_i[14:0]] <= pri_mem[addr_i[14:0]] & wdata_i;
        end
    end

    // Registered read port.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= is_sec(addr_i) ? sec_mem[addr_i[11:0]] : pri_mem[addr_i[14:0]];
        end
    end

    assign rdata_o = rdata_q;

endmodule // iafms_array

//--- rtl/iafms_seq.sv
// Mailbox sequencer top: SFR slave for the five mailbox registers and the operation state machine.
// Assumes single-cycle SFR write and read strobes from the CPU core, synchronous to sys_clk_i.
`timescale 1ns/10ps
module iafms_seq
    import iafms_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic in_application_programming_mode_i,
    input wire logic external_access_n_i,
    input wire logic pc_in_secondary_i,
    input wire logic lock_primary_i,
    input wire logic lock_secondary_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    output logic second_external_interrupt_n_o,
    output logic primary_busy_o,
    output logic secondary_busy_o
);

    typedef enum logic [1:0] {
        IAFMS_IDLE = 2'b00,
        IAFMS_RUN = 2'b01,
        IAFMS_VERIFY = 2'b10,
        IAFMS_VLOAD = 2'b11
    } iafms_state_t;

    typedef enum logic [2:0] {
        IAFMS_OP_NONE = 3'b000,
        IAFMS_OP_CHIP = 3'b001,
        IAFMS_OP_BLOCK = 3'b010,
        IAFMS_OP_SECTOR = 3'b011,
        IAFMS_OP_PROG = 3'b100
    } iafms_op_t;

    typedef struct packed {
        iafms_state_t st;
        iafms_op_t op;
        logic [7:0] data;
        logic [7:0] addr_lo;
        logic [7:0] addr_hi;
        logic [7:0] cmd;
        logic [2:0] prescale;
        logic busy;
        logic irq_en;
        logic irq_n;
        logic unlock_pri;
        logic unlock_sec;
        logic [7:0] rdata;
        logic pri_busy;
        logic sec_busy;
        logic [IAFMS_TIMER_W-1:0] run_cnt;
    } iafms_seq_t;

    iafms_seq_t s_q, s_d;
    logic tmr_start, tmr_erase, tmr_done;
    logic [7:0] arr_rdata;
    logic lock_pri, lock_sec, tgt_sec, tgt_locked, cmd_wr;
    logic [6:0] code;

    // Effective locks: a chip erase clears them until the next reset reloads the security byte.
    assign lock_pri = lock_primary_i & ~s_q.unlock_pri;
    assign lock_sec = lock_secondary_i & ~s_q.unlock_sec;
    assign tgt_sec = (s_q.addr_hi[7:4] == IAFMS_SEL_SECONDARY);
    assign tgt_locked = tgt_sec ? lock_sec : lock_pri;
    assign cmd_wr = sfr_wr_i && (sfr_addr_i == IAFMS_OFS_CMD) && in_application_programming_mode_i;
    assign code = sfr_wdata_i[6:0];

    // Decode of a written command into an operation kind; unknown codes give none.
    function automatic iafms_op_t iafms_decode(input logic [6:0] c);
        case (c)
            IAFMS_CMD_CHIP_ERASE: return IAFMS_OP_CHIP;
            IAFMS_CMD_BLOCK_ERASE: return IAFMS_OP_BLOCK;
            IAFMS_CMD_SECTOR_ERASE: return IAFMS_OP_SECTOR;
            IAFMS_CMD_BYTE_PROG: return IAFMS_OP_PROG;
            IAFMS_CMD_BURST_PROG: return IAFMS_OP_PROG;
            default: return IAFMS_OP_NONE;
        endcase
    endfunction

    // Register writes, command acceptance and the operation state machine.
    always_comb begin
        iafms_op_t op_new;
        op_new = iafms_decode(code);
        s_d = s_q;
        tmr_start = 1'b0;
        tmr_erase = 1'b0;
        // Cycles spent busy so far; only the length check below reads it.
        s_d.run_cnt = s_q.busy ? s_q.run_cnt + 16'h0001 : 16'h0000;
        if (sfr_wr_i && !s_q.busy) begin
            case (sfr_addr_i)
                IAFMS_OFS_DATA: s_d.data = sfr_wdata_i;
                IAFMS_OFS_ADDR_LO: s_d.addr_lo = sfr_wdata_i;
                IAFMS_OFS_ADDR_HI: s_d.addr_hi = sfr_wdata_i;
                IAFMS_OFS_CFG: s_d.prescale = sfr_wdata_i[2:0];
                IAFMS_OFS_CMD: s_d.cmd = sfr_wdata_i;
                default: s_d.cmd = s_q.cmd;
            endcase
        end
        // A read of the configuration/status register clears a pending completion interrupt.
        if (sfr_rd_i && sfr_addr_i == IAFMS_OFS_CFG) begin
            s_d.irq_n = 1'b1;
        end
        case (s_q.st)
            IAFMS_IDLE: begin
                if (cmd_wr) begin
                    if (code == IAFMS_CMD_BYTE_VERIFY && !tgt_locked) begin
                        s_d.st = IAFMS_VERIFY;
                    end else if (op_new != IAFMS_OP_NONE && (op_new == IAFMS_OP_CHIP || !tgt_locked)) begin
                        // Chip and block erases also need the key in the data mailbox as a second guard.
                        if ((op_new == IAFMS_OP_CHIP || op_new == IAFMS_OP_BLOCK) && s_q.data != IAFMS_ERASE_KEY) begin
                            s_d.st = IAFMS_IDLE;
                        end else begin
                            s_d.st = IAFMS_RUN;
                            s_d.op = op_new;
                            s_d.busy = 1'b1;
                            s_d.irq_en = sfr_wdata_i[IAFMS_CMD_IRQ_BIT];
                            tmr_start = 1'b1;
                            tmr_erase = (op_new != IAFMS_OP_PROG);
                            s_d.pri_busy = (op_new == IAFMS_OP_CHIP) || !tgt_sec;
                            s_d.sec_busy = (op_new == IAFMS_OP_CHIP) || tgt_sec;
                        end
                    end
                end
            end
            IAFMS_RUN: begin
                if (tmr_done) begin
                    s_d.st = IAFMS_IDLE;
                    s_d.busy = 1'b0;
                    s_d.op = IAFMS_OP_NONE;
                    s_d.pri_busy = 1'b0;
                    s_d.sec_busy = 1'b0;
                    if (s_q.irq_en) begin
                        s_d.irq_n = 1'b0;
                    end
                    if (s_q.op == IAFMS_OP_CHIP) begin
                        s_d.unlock_pri = 1'b1;
                        s_d.unlock_sec = 1'b1;
                    end
                end
            end
            IAFMS_VERIFY: s_d.st = IAFMS_VLOAD;
            IAFMS_VLOAD: begin
                s_d.data = arr_rdata;
                s_d.st = IAFMS_IDLE;
            end
            default: s_d.st = IAFMS_IDLE;
        endcase
        // Registered read data; unmapped offsets read zero.
        case (sfr_addr_i)
            IAFMS_OFS_CFG: s_d.rdata = {1'b0, pc_in_secondary_i, lock_sec, lock_pri, s_q.busy, s_q.prescale};
            IAFMS_OFS_DATA: s_d.rdata = s_q.data;
            IAFMS_OFS_ADDR_LO: s_d.rdata = s_q.addr_lo;
            IAFMS_OFS_ADDR_HI: s_d.rdata = s_q.addr_hi;
            IAFMS_OFS_CMD: s_d.rdata = s_q.cmd;
            default: s_d.rdata = 8'h00;
        endcase
    end

    // State register; the external access pin plays no part, so either level works.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
            // The request line idles high so no false interrupt follows reset.
            s_q.irq_n <= 1'b1;
            s_q.prescale <= IAFMS_PRESCALE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    iafms_timer u_timer (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(tmr_start),
        .erase_i(tmr_erase),
        .clock_prescale_factor_i(s_q.prescale),
        .done_o(tmr_done)
    );

    // Flash action fires on the timer's last cycle so busy and data change together.
    iafms_array u_array (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .addr_i({s_q.addr_hi, s_q.addr_lo}),
        .wdata_i(s_q.data),
        .prog_i(tmr_done && s_q.op == IAFMS_OP_PROG),
        .erase_chip_i(tmr_done && s_q.op == IAFMS_OP_CHIP),
        .erase_block_i(tmr_done && s_q.op == IAFMS_OP_BLOCK),
        .erase_sector_i(tmr_done && s_q.op == IAFMS_OP_SECTOR),
        .rdata_o(arr_rdata)
    );

    // Every output comes straight from a state flip-flop.
    assign sfr_rdata_o = s_q.rdata;
    assign second_external_interrupt_n_o = s_q.irq_n;
    assign primary_busy_o = s_q.pri_busy;
    assign secondary_busy_o = s_q.sec_busy;

    // Checks kept beside the logic they guard.
    sequence iafms_accept_s;
        s_q.st == IAFMS_IDLE && cmd_wr && iafms_decode(code) == IAFMS_OP_PROG && !tgt_locked;
    endsequence

    mode_gate_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (sfr_wr_i && sfr_addr_i == IAFMS_OFS_CMD && !in_application_programming_mode_i && !s_q.busy)
        |=> !s_q.busy) else $error("command acted outside programming mode");
    lock_ignore_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.st == IAFMS_IDLE && cmd_wr && tgt_locked && code != IAFMS_CMD_CHIP_ERASE) |=> !s_q.busy)
        else $error("locked block command was not ignored");
    busy_set_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        iafms_accept_s |=> s_q.busy && s_q.pri_busy != s_q.sec_busy) else $error("busy not set on accept");
    busy_clear_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.busy && tmr_done) |=> !s_q.busy
        ##1 (sfr_rdata_o[IAFMS_CFG_BUSY_BIT] == 1'b0 || $past(sfr_addr_i) != IAFMS_OFS_CFG))
        else $error("busy not cleared at finish");
    irq_raise_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.busy && tmr_done && s_q.irq_en) |=> !second_external_interrupt_n_o)
        else $error("completion interrupt missing");
    irq_quiet_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.busy && tmr_done && !s_q.irq_en) |=> $stable(second_external_interrupt_n_o) || s_q.irq_n)
        else $error("interrupt raised with polling chosen");
    bad_code_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.st == IAFMS_IDLE && cmd_wr && iafms_decode(code) == IAFMS_OP_NONE) |=> s_q.st != IAFMS_RUN)
        else $error("unknown code started an operation");
    erase_key_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.st == IAFMS_IDLE && cmd_wr && code == IAFMS_CMD_CHIP_ERASE && s_q.data != IAFMS_ERASE_KEY) |=> !s_q.busy)
        else $error("erase ran without key");
    verify_load_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.st == IAFMS_VERIFY) |=> s_q.st == IAFMS_VLOAD ##1 s_q.st == IAFMS_IDLE)
        else $error("verify did not load data");

    // Register bus checks: only a command write starts work, and the data and address mailboxes hold while busy.
    only_cmd_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.st == IAFMS_IDLE && sfr_wr_i && sfr_addr_i != IAFMS_OFS_CMD) |=> s_q.st == IAFMS_IDLE && !s_q.busy)
        else $error("non-command write started an operation");
    busy_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.busy && sfr_wr_i) |=> $stable(s_q.data) && $stable(s_q.addr_lo) && $stable(s_q.addr_hi))
        else $error("mailbox changed during an operation");
    cfg_view_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (sfr_addr_i == IAFMS_OFS_CFG) |=> sfr_rdata_o[IAFMS_CFG_BUSY_BIT] == $past(s_q.busy)
        && sfr_rdata_o[IAFMS_CFG_LOCK_PRI_BIT] == $past(lock_pri)
        && sfr_rdata_o[IAFMS_CFG_LOCK_SEC_BIT] == $past(lock_sec)
        && sfr_rdata_o[IAFMS_CFG_PC_SEC_BIT] == $past(pc_in_secondary_i))
        else $error("status view is wrong");

    // Erase checks: both blocks held by a keyed chip erase, the choice of block and the lifted locks after chip erase.
    sequence iafms_keyed_s;
        s_q.st == IAFMS_IDLE && cmd_wr && s_q.data == IAFMS_ERASE_KEY;
    endsequence

    chip_both_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (iafms_keyed_s ##0 (code == IAFMS_CMD_CHIP_ERASE)) |=> s_q.busy && s_q.pri_busy && s_q.sec_busy)
        else $error("chip erase did not hold both blocks");
    block_pick_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (iafms_keyed_s ##0 (code == IAFMS_CMD_BLOCK_ERASE && !tgt_locked))
        |=> s_q.busy && s_q.sec_busy == tgt_sec && s_q.pri_busy == !tgt_sec)
        else $error("block erase picked the wrong block");
    chip_unlock_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.busy && tmr_done && s_q.op == IAFMS_OP_CHIP) |=> !lock_pri && !lock_sec)
        else $error("chip erase left a block locked");

    // Timing, block ownership, interrupt holding and verify load.
    op_length_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.busy && tmr_done) |-> int'(s_q.run_cnt) == (int'(s_q.prescale) + 1)
        * ((s_q.op == IAFMS_OP_PROG) ? IAFMS_PROG_CYCLES : IAFMS_ERASE_CYCLES))
        else $error("operation length does not follow the prescale factor");
    one_block_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.pri_busy && s_q.sec_busy) |-> s_q.op == IAFMS_OP_CHIP)
        else $error("one-block operation held both blocks");
    irq_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (!second_external_interrupt_n_o && !(sfr_rd_i && sfr_addr_i == IAFMS_OFS_CFG))
        |=> !second_external_interrupt_n_o)
        else $error("interrupt dropped before a status read");
    vload_data_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.st == IAFMS_VLOAD) |=> s_q.data == $past(arr_rdata))
        else $error("verify byte not loaded");

endmodule // iafms_seq

//--- bench/iafms_cpu_model.sv
// CPU-side model that drives the special function register bus of the sequencer.
// Assumes read data is registered one cycle after the address is presented.
`timescale 1ns/10ps
module iafms_cpu_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] sfr_rdata_i,
    output logic sfr_wr_o,
    output logic sfr_rd_o,
    output logic [7:0] sfr_addr_o,
    output logic [7:0] sfr_wdata_o,
    output logic rd_done_o,
    output logic [7:0] rd_data_o
);
    // Idle bus at time zero.
    initial begin
        sfr_wr_o = 1'b0;
        sfr_rd_o = 1'b0;
        sfr_addr_o = 8'h00;
        sfr_wdata_o = 8'h00;
        rd_done_o = 1'b0;
        rd_data_o = 8'h00;
    end
    // One-cycle write strobe; released lines show inverted values so stale data is never mistaken.
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        sfr_addr_o = a;
        sfr_wdata_o = d;
        sfr_wr_o = 1'b1;
        @(negedge sys_clk_i);
        sfr_wr_o = 1'b0;
        sfr_addr_o = ~a;
        sfr_wdata_o = ~d;
    endtask
    // Read: data is taken one cycle after the address and flagged for one cycle.
    task automatic sfr_read(input logic [7:0] a);
        @(negedge sys_clk_i);
        sfr_addr_o = a;
        sfr_rd_o = 1'b1;
        @(negedge sys_clk_i);
        sfr_rd_o = 1'b0;
        sfr_addr_o = ~a;
        rd_data_o = sfr_rdata_i;
        rd_done_o = 1'b1;
        @(negedge sys_clk_i);
        rd_done_o = 1'b0;
    endtask
endmodule // iafms_cpu_model

//--- bench/testbench.sv
// Self-checking bench for the mailbox sequencer: registers, commands, locks, interrupt and timing.
// Assumes read data one cycle after the address and a config read clearing the interrupt.
`timescale 1ns/10ps
module testbench;
    import iafms_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic in_application_programming_mode = 1'b1;
    logic ea_n = 1'b0;
    logic pc_sec = 1'b0;
    logic lk_p = 1'b0;
    logic lk_s = 1'b0;
    logic cleared = 1'b0;
    logic wr, rd, done, irq_n, pbusy, sbusy;
    logic [7:0] addr, wdata, rdata, rdd, expd, d0, d1, d2;
    logic [2:0] presc = 3'h0;
    logic [7:0] exp_q[$];
    logic [7:0] codes [4] = '{8'h0E, 8'h8E, 8'h0A, 8'h8A};
    int seed = 13;
    int miscompares = 0;
    int n_compared = 0;
    int cyc, k;
    wire busy_any = pbusy | sbusy;

    // 250 MHz clock.
    always #2 sys_clk_i = ~sys_clk_i;

    iafms_seq u_iafms_seq (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .in_application_programming_mode_i(in_application_programming_mode), .external_access_n_i(ea_n), .pc_in_secondary_i(pc_sec),
        .lock_primary_i(lk_p), .lock_secondary_i(lk_s), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_addr_i(addr),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .second_external_interrupt_n_o(irq_n),
        .primary_busy_o(pbusy), .secondary_busy_o(sbusy));
    iafms_cpu_model u_iafms_cpu_model (.sys_clk_i(sys_clk_i), .sfr_rdata_i(rdata), .sfr_wr_o(wr), .sfr_rd_o(rd),
        .sfr_addr_o(addr), .sfr_wdata_o(wdata), .rd_done_o(done), .rd_data_o(rdd));

    // Read monitor: each read result is matched against the oldest noted expectation.
    always @(posedge sys_clk_i) begin
        if (done) begin
            expd = (exp_q.size() > 0) ? exp_q.pop_front() : ~rdd;
            n_compared++;
            if (rdd !== expd) begin
                miscompares++;
                $display("[FAIL] %0t read %h expected %h", $time, rdd, expd);
            end
        end
    end

    function automatic logic [7:0] cfg_val();
        return {1'b0, pc_sec, lk_s & ~cleared, lk_p & ~cleared, 1'b0, presc};
    endfunction
    function automatic int tp();
        return 10 * (int'(presc) + 1);
    endfunction
    function automatic int te();
        return 100 * (int'(presc) + 1);
    endfunction
    task automatic end_of_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic exp_rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_iafms_cpu_model.sfr_read(a);
    endtask
    task automatic setp(input logic [2:0] p);
        presc = p;
        d0 = 8'($random(seed));
        u_iafms_cpu_model.sfr_write(IAFMS_OFS_CFG, {d0[7:3], p});
    endtask
    task automatic cmd(input logic [7:0] h, input logic [7:0] l, input logic [7:0] d, input logic [7:0] c);
        u_iafms_cpu_model.sfr_write(IAFMS_OFS_ADDR_HI, h);
        u_iafms_cpu_model.sfr_write(IAFMS_OFS_ADDR_LO, l);
        u_iafms_cpu_model.sfr_write(IAFMS_OFS_DATA, d);
        u_iafms_cpu_model.sfr_write(IAFMS_OFS_CMD, c);
    endtask
    // A refused command must start nothing and raise no interrupt.
    task automatic nob(input logic [7:0] h, input logic [7:0] l, input logic [7:0] d, input logic [7:0] c);
        cmd(h, l, d, c);
        repeat (3) @(negedge sys_clk_i);
        chk({5'h00, pbusy, sbusy, irq_n}, 8'h01);
    endtask
    // Accepted operation: busy length, busy block, then interrupt per bit 7 and its clear by a config read.
    task automatic op(input logic [7:0] h, l, d, c, input int n, input logic [1:0] blk, input logic peek);
        logic [1:0] seen;
        int p3;
        seen = 2'b00;
        p3 = peek ? 3 : 0;
        cmd(h, l, d, c);
        if (peek) exp_rd(IAFMS_OFS_CFG, cfg_val() | 8'h08);
        for (cyc = 0; cyc < 4000 && busy_any; cyc++) begin
            seen = seen | {sbusy, pbusy};
            @(negedge sys_clk_i);
        end
        if (cyc == 4000) begin
            miscompares++;
            $display("[FAIL] %0t operation never finished", $time);
            end_of_test();
        end
        chk(8'(cyc >= n - 1 - p3 && cyc <= n + 2 - p3), 8'h01);
        chk({6'h00, seen}, {6'h00, blk});
        repeat (2) @(negedge sys_clk_i);
        chk({7'h00, irq_n}, {7'h00, ~c[7]});
        if (c[7]) begin
            exp_rd(IAFMS_OFS_CFG, cfg_val());
            chk({7'h00, irq_n}, 8'h01);
        end
    endtask
    task automatic ver(input logic [7:0] h, input logic [7:0] l, input logic [7:0] e, input logic [7:0] c = 8'h0C);
        cmd(h, l, 8'h00, c);
        repeat (4) @(negedge sys_clk_i);
        exp_rd(IAFMS_OFS_DATA, e);
        if (c[7]) exp_rd(IAFMS_OFS_CFG, cfg_val());
    endtask

    // Main sequence: reset, refusals, erase and program paths, timing per prescale.
    initial begin
        repeat (12) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        for (k = 0; k < 6; k++) exp_rd((k == 5) ? 8'h80 : 8'hF7 + 8'(k), 8'h00);
        pc_sec = 1'b1;
        lk_p = 1'b1;
        lk_s = 1'b1;
        setp(3'($random(seed)));
        exp_rd(IAFMS_OFS_CFG, cfg_val());
        chk({6'h00, pbusy, sbusy}, 8'h00);
        in_application_programming_mode = 1'b0;
        nob(8'h01, 8'h23, 8'hAA, 8'h0E);
        in_application_programming_mode = 1'b1;
        nob(8'h01, 8'h23, 8'h5A, 8'h8E);
        nob(8'hF0, 8'h00, 8'h55, 8'h8F);
        nob(8'h00, 8'h00, 8'hAA, 8'h87);
        nob(8'h00, 8'h00, 8'h55, 8'h05);
        nob(8'h00, 8'h00, 8'h55, 8'h85);
        pc_sec = 1'b0;
        cleared = 1'b1;
        op(8'h00, 8'h00, 8'h55, 8'h87, te(), 2'b11, 1'b0);
        ea_n = 1'b1;
        pc_sec = 1'b1;
        ver(8'h00, 8'h00, 8'hFF);
        ver(8'hF0, 8'h3F, 8'hFF);
        for (k = 0; k < 4; k++) begin
            setp(3'(2 * k));
            d0 = 8'($random(seed));
            op(8'h12, 8'(k), d0, codes[k], tp(), 2'b01, 1'b0);
            ver(8'h12, 8'(k), d0);
        end
        setp(3'h1);
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        op(8'h02, 8'h00, d1, 8'h0E, tp(), 2'b01, 1'b0);
        op(8'h02, 8'h7F, d1, 8'h0E, tp(), 2'b01, 1'b0);
        op(8'h02, 8'h80, d2, 8'h0E, tp(), 2'b01, 1'b0);
        op(8'h02, 8'h40, 8'h00, 8'h0B, te(), 2'b01, 1'b1);
        ver(8'h02, 8'h00, 8'hFF);
        ver(8'h02, 8'h7F, 8'hFF);
        ver(8'h02, 8'h80, d2);
        pc_sec = 1'b0;
        op(8'hF0, 8'h3F, d1, 8'h0E, tp(), 2'b10, 1'b0);
        op(8'hF0, 8'h40, d2, 8'h0E, tp(), 2'b10, 1'b0);
        op(8'hF0, 8'h00, 8'h00, 8'h8B, te(), 2'b10, 1'b0);
        ver(8'hF0, 8'h3F, 8'hFF);
        ver(8'hF0, 8'h40, d2);
        nob(8'hF0, 8'h00, 8'hAA, 8'h0F);
        op(8'hF0, 8'h00, 8'h55, 8'h0F, te(), 2'b10, 1'b0);
        ver(8'hF0, 8'h40, 8'hFF);
        ver(8'h02, 8'h80, d2);
        pc_sec = 1'b1;
        op(8'h05, 8'h00, 8'h55, 8'h8F, te(), 2'b01, 1'b0);
        ver(8'h02, 8'h80, 8'hFF, 8'h8C);
        repeat (3) @(negedge sys_clk_i);
        end_of_test();
    end
endmodule // testbench
